// file: rtl/sit_defines.svh
// Purpose: constants of the sleep interval timer
// Assumes: 100 MHz clk, AXI4-Lite, byte address = 4 * register index
// Notes:   register indices are word indices on the bus
// Function
// RULE1: hold 11-bit wake value; coarse match requests main oscillator start.
// RULE2: wake value resets to 0x00A; software never programs below 0x001.
// RULE3: software keeps wake value above the oscillator settle count.
// RULE4: wake value bits 10:8 in high wake byte bits 2:0, rest zero.
// RULE5: fine counter is 16 bits over two bytes, counting 50 ns ticks.
// RULE6: coarse counter is 26 bits over byte registers, in low-power periods.
// RULE7: coarse plus fine time beacon intervals, or sleep without beacons.
// RULE8: low-power period set by selected clock source and programmed divisor.
// RULE9: writing start bit launches nonbeacon sleep timing; bit self-clears.
// RULE10: coarse bits 25:24 sit in bits 1:0 of fourth coarse byte.
// RULE11: interval ends after coarse periods then fine ticks have elapsed.
`ifndef SIT_DEFINES_SVH
`define SIT_DEFINES_SVH

// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define SIT_IDX_WAKE_LOW    10'h222
`define SIT_IDX_WAKE_HIGH   10'h223
`define SIT_IDX_FINE_LOW    10'h224
`define SIT_IDX_FINE_HIGH   10'h225
`define SIT_IDX_COARSE0     10'h226
`define SIT_IDX_COARSE1     10'h227
`define SIT_IDX_COARSE2     10'h228
`define SIT_IDX_COARSE3     10'h229
`define SIT_IDX_CTRL        10'h22C
`define SIT_IDX_STATUS      10'h22D

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define SIT_START_BIT       7
`define SIT_WAKE_RESET      11'h00A
`define SIT_ORDER_RESET     4'hF
`define SIT_ORDER_NONBEACON 4'hF
`define SIT_RESP_OKAY       2'h0
`define SIT_RESP_SLVERR     2'h2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SIT_CLK_NS          10
`define SIT_FINE_TICK_NS    50
`define SIT_FINE_CYC        (`SIT_FINE_TICK_NS / `SIT_CLK_NS)
`define SIT_LP_INT_NS       10000
`define SIT_LP_EXT_NS       30518
`define SIT_LP_INT_CYC      (`SIT_LP_INT_NS / `SIT_CLK_NS)
`define SIT_LP_EXT_CYC      (`SIT_LP_EXT_NS / `SIT_CLK_NS)

`endif

// file: rtl/sit_pkg.sv
// Purpose: types of the sleep interval timer
// Assumes: constants live in sit_defines.svh
// Notes:   none
package sit_pkg;

    typedef enum logic [1:0] {
        SIT_IDLE,
        SIT_COARSE,
        SIT_FINE
    } sit_phase_t;

    typedef enum logic [3:0] {
        SIT_SEL_NONE,
        SIT_SEL_WAKE_LOW,
        SIT_SEL_WAKE_HIGH,
        SIT_SEL_FINE_LOW,
        SIT_SEL_FINE_HIGH,
        SIT_SEL_COARSE0,
        SIT_SEL_COARSE1,
        SIT_SEL_COARSE2,
        SIT_SEL_COARSE3,
        SIT_SEL_CTRL,
        SIT_SEL_STATUS
    } sit_sel_t;

endpackage

// file: rtl/sit_sleep_interval_timer.sv
// Purpose: sleep interval timer with AXI4-Lite register access
// Assumes: single 100 MHz clock, synchronous active-low reset
// Notes:   low-power clock is a tick enable derived from clk
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "sit_defines.svh"

module sit_sleep_interval_timer
    import sit_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        beaconStart,
    output logic             oscWakeReq,
    output logic             intervalDone,
    output logic             sleepActive
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [10:0] wakeMatch;
        logic [15:0] fineCfg;
        logic [25:0] coarseCfg;
        logic [1:0]  lpSrc;
        logic [4:0]  lpDiv;
        logic [3:0]  beaconOrder;
        logic        slotted;
        sit_phase_t  phase;
        logic [25:0] coarseLeft;
        logic [15:0] fineLeft;
        logic [2:0]  tickCnt;
        logic [11:0] baseCnt;
        logic [31:0] divCnt;
        logic        oscWake;
        logic        done;
        logic        doneSticky;
        logic        active;
        logic        awHeld;
        logic        wHeld;
        logic [11:0] awAddr;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        logic        awReady;
        logic        wReady;
        logic        bValid;
        logic [1:0]  bResp;
        logic        arReady;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
    } sit_state_t;

    sit_state_t s;
    sit_state_t next_s;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic sit_sel_t decodeAddr(input logic [11:0] addr);
        unique case (addr[11:2])
            `SIT_IDX_WAKE_LOW:  decodeAddr = SIT_SEL_WAKE_LOW;
            `SIT_IDX_WAKE_HIGH: decodeAddr = SIT_SEL_WAKE_HIGH;
            `SIT_IDX_FINE_LOW:  decodeAddr = SIT_SEL_FINE_LOW;
            `SIT_IDX_FINE_HIGH: decodeAddr = SIT_SEL_FINE_HIGH;
            `SIT_IDX_COARSE0:   decodeAddr = SIT_SEL_COARSE0;
            `SIT_IDX_COARSE1:   decodeAddr = SIT_SEL_COARSE1;
            `SIT_IDX_COARSE2:   decodeAddr = SIT_SEL_COARSE2;
            `SIT_IDX_COARSE3:   decodeAddr = SIT_SEL_COARSE3;
            `SIT_IDX_CTRL:      decodeAddr = SIT_SEL_CTRL;
            `SIT_IDX_STATUS:    decodeAddr = SIT_SEL_STATUS;
            default:            decodeAddr = SIT_SEL_NONE;
        endcase
    endfunction

    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb);
        mergeBytes = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                mergeBytes[i*8 +: 8] = data[i*8 +: 8];
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // combinational next state
    // ------------------------------------------------------------------
    logic        nonBeacon;
    logic        baseTick;
    logic        lpTick;
    logic        fineTick;
    logic        doWrite;
    logic        wrStart;
    logic        startNow;
    logic [31:0] divMask;
    logic [11:0] basePeriod;
    logic [31:0] wMerged;
    sit_sel_t    wSel;
    sit_sel_t    rSel;

    always_comb begin
        next_s = s;
        // nonbeacon mode: order 0xF with slotted access off [RULE9]
        nonBeacon = (s.beaconOrder == `SIT_ORDER_NONBEACON) && !s.slotted;
        // source picks the base period, divisor scales it by 2^n [RULE8]
        basePeriod = (s.lpSrc == 2'h0) ? 12'(`SIT_LP_INT_CYC)
                                       : 12'(`SIT_LP_EXT_CYC);
        baseTick = s.active && (s.baseCnt == basePeriod - 12'h001);
        divMask  = (32'h0000_0001 << s.lpDiv) - 32'h0000_0001;
        lpTick   = baseTick && ((s.divCnt & divMask) == divMask); // [RULE8]
        // fine tick every 50 ns [RULE5]
        fineTick = s.active && (s.tickCnt == 3'(`SIT_FINE_CYC - 1));

        // write channel: address and data taken in either order
        next_s.done = 1'b0;
        if (s_axi_awvalid && s.awReady) begin
            next_s.awHeld = 1'b1;
            next_s.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wReady) begin
            next_s.wHeld = 1'b1;
            next_s.wData = s_axi_wdata;
            next_s.wStrb = s_axi_wstrb;
        end
        if (s.bValid && s_axi_bready) begin
            next_s.bValid = 1'b0;
        end
        doWrite = s.awHeld && s.wHeld && !s.bValid;
        wSel    = decodeAddr(s.awAddr);
        wMerged = 32'h0000_0000;
        wrStart = 1'b0;
        if (doWrite) begin
            next_s.awHeld = 1'b0;
            next_s.wHeld  = 1'b0;
            next_s.bValid = 1'b1;
            next_s.bResp  = `SIT_RESP_OKAY;
            unique case (wSel)
                SIT_SEL_WAKE_LOW: begin
                    wMerged = mergeBytes({24'h0, s.wakeMatch[7:0]},
                                         s.wData, s.wStrb);
                    next_s.wakeMatch[7:0] = wMerged[7:0]; // [RULE1]
                end
                SIT_SEL_WAKE_HIGH: begin
                    wMerged = mergeBytes({29'h0, s.wakeMatch[10:8]},
                                         s.wData, s.wStrb);
                    next_s.wakeMatch[10:8] = wMerged[2:0]; // [RULE4]
                end
                SIT_SEL_FINE_LOW: begin
                    wMerged = mergeBytes({24'h0, s.fineCfg[7:0]},
                                         s.wData, s.wStrb);
                    next_s.fineCfg[7:0] = wMerged[7:0]; // [RULE5]
                end
                SIT_SEL_FINE_HIGH: begin
                    wMerged = mergeBytes({24'h0, s.fineCfg[15:8]},
                                         s.wData, s.wStrb);
                    next_s.fineCfg[15:8] = wMerged[7:0]; // [RULE5]
                end
                SIT_SEL_COARSE0: begin
                    wMerged = mergeBytes({24'h0, s.coarseCfg[7:0]},
                                         s.wData, s.wStrb);
                    next_s.coarseCfg[7:0] = wMerged[7:0]; // [RULE6]
                end
                SIT_SEL_COARSE1: begin
                    wMerged = mergeBytes({24'h0, s.coarseCfg[15:8]},
                                         s.wData, s.wStrb);
                    next_s.coarseCfg[15:8] = wMerged[7:0]; // [RULE6]
                end
                SIT_SEL_COARSE2: begin
                    wMerged = mergeBytes({24'h0, s.coarseCfg[23:16]},
                                         s.wData, s.wStrb);
                    next_s.coarseCfg[23:16] = wMerged[7:0]; // [RULE6]
                end
                SIT_SEL_COARSE3: begin
                    wMerged = mergeBytes({30'h0, s.coarseCfg[25:24]},
                                         s.wData, s.wStrb);
                    next_s.coarseCfg[25:24] = wMerged[1:0]; // [RULE10]
                    // start bit is not stored, so it reads back zero [RULE9]
                    wrStart = wMerged[`SIT_START_BIT];
                end
                SIT_SEL_CTRL: begin
                    wMerged = mergeBytes({20'h0, s.slotted, s.beaconOrder,
                                          s.lpDiv, s.lpSrc},
                                         s.wData, s.wStrb);
                    next_s.lpSrc       = wMerged[1:0];
                    next_s.lpDiv       = wMerged[6:2];
                    next_s.beaconOrder = wMerged[10:7];
                    next_s.slotted     = wMerged[11];
                end
                SIT_SEL_STATUS: begin
                    // write one clears the done flag
                    if (s.wStrb[0] && s.wData[2]) begin
                        next_s.doneSticky = 1'b0;
                    end
                end
                SIT_SEL_NONE: begin
                    next_s.bResp = `SIT_RESP_SLVERR;
                end
            endcase
        end

        // read channel: one outstanding read, answered one cycle later
        rSel = decodeAddr(s_axi_araddr);
        if (s.rValid && s_axi_rready) begin
            next_s.rValid = 1'b0;
        end
        if (s_axi_arvalid && s.arReady) begin
            next_s.rValid = 1'b1;
            next_s.rResp  = `SIT_RESP_OKAY;
            unique case (rSel)
                SIT_SEL_WAKE_LOW:  next_s.rData = {24'h0, s.wakeMatch[7:0]};
                SIT_SEL_WAKE_HIGH: next_s.rData = {29'h0, s.wakeMatch[10:8]};
                SIT_SEL_FINE_LOW:  next_s.rData = {24'h0, s.fineCfg[7:0]};
                SIT_SEL_FINE_HIGH: next_s.rData = {24'h0, s.fineCfg[15:8]};
                SIT_SEL_COARSE0:   next_s.rData = {24'h0, s.coarseCfg[7:0]};
                SIT_SEL_COARSE1:   next_s.rData = {24'h0, s.coarseCfg[15:8]};
                SIT_SEL_COARSE2:   next_s.rData = {24'h0, s.coarseCfg[23:16]};
                SIT_SEL_COARSE3:   next_s.rData = {30'h0, s.coarseCfg[25:24]};
                SIT_SEL_CTRL:      next_s.rData = {20'h0, s.slotted,
                                                   s.beaconOrder, s.lpDiv,
                                                   s.lpSrc};
                SIT_SEL_STATUS:    next_s.rData = {28'h0, nonBeacon,
                                                   s.doneSticky, s.oscWake,
                                                   s.active};
                SIT_SEL_NONE: begin
                    next_s.rData = 32'h0000_0000;
                    next_s.rResp = `SIT_RESP_SLVERR;
                end
            endcase
        end

        // low-power and fine tick generation
        if (s.active) begin
            next_s.baseCnt = baseTick ? 12'h000 : s.baseCnt + 12'h001;
            next_s.tickCnt = fineTick ? 3'h0 : s.tickCnt + 3'h1;
            if (baseTick) begin
                next_s.divCnt = s.divCnt + 32'h0000_0001;
            end
        end

        // interval sequencer
        unique case (s.phase)
            SIT_IDLE: begin
            end
            SIT_COARSE: begin
                if (s.coarseLeft <= {15'h0, s.wakeMatch}) begin
                    next_s.oscWake = 1'b1; // [RULE1]
                end
                if (s.coarseLeft == 26'h0) begin
                    next_s.phase = SIT_FINE; // [RULE11]
                end else if (lpTick) begin
                    next_s.coarseLeft = s.coarseLeft - 26'h1; // [RULE6]
                end
            end
            SIT_FINE: begin
                next_s.oscWake = 1'b1;
                if (s.fineLeft == 16'h0) begin
                    // end only after both phases have run out [RULE11]
                    next_s.phase      = SIT_IDLE;
                    next_s.active     = 1'b0;
                    next_s.done       = 1'b1;
                    next_s.doneSticky = 1'b1;
                end else if (fineTick) begin
                    next_s.fineLeft = s.fineLeft - 16'h1; // [RULE5]
                end
            end
        endcase

        // beacon mode starts from the radio, nonbeacon from software [RULE7]
        startNow = (wrStart && nonBeacon) || (beaconStart && !nonBeacon);
        if (startNow) begin // [RULE9]
            next_s.phase      = SIT_COARSE;
            next_s.active     = 1'b1;
            next_s.coarseLeft = s.coarseCfg;
            next_s.fineLeft   = s.fineCfg;
            next_s.baseCnt    = 12'h000;
            next_s.divCnt     = 32'h0000_0000;
            next_s.tickCnt    = 3'h0;
            next_s.oscWake    = 1'b0;
        end

        // ready flags registered so every port comes from a flop
        next_s.awReady = !next_s.awHeld && !next_s.bValid;
        next_s.wReady  = !next_s.wHeld && !next_s.bValid;
        next_s.arReady = !next_s.rValid;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s             <= '0;
            s.wakeMatch   <= `SIT_WAKE_RESET; // [RULE2]
            s.beaconOrder <= `SIT_ORDER_RESET;
            s.phase       <= SIT_IDLE;
            s.awReady     <= 1'b1;
            s.wReady      <= 1'b1;
            s.arReady     <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready = s.awReady;
    assign s_axi_wready  = s.wReady;
    assign s_axi_bvalid  = s.bValid;
    assign s_axi_bresp   = s.bResp;
    assign s_axi_arready = s.arReady;
    assign s_axi_rvalid  = s.rValid;
    assign s_axi_rdata   = s.rData;
    assign s_axi_rresp   = s.rResp;
    assign oscWakeReq    = s.oscWake;
    assign intervalDone  = s.done;
    assign sleepActive   = s.active;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence coarseRanOut;
        s.phase == SIT_COARSE ##1 s.phase == SIT_FINE;
    endsequence

    sequence fineRanOut;
        s.phase == SIT_FINE && s.fineLeft == 16'h0 && !startNow;
    endsequence

    chk_wake_reset_val: assert property ( // [RULE2]
        $rose(nrst) |-> s.wakeMatch == 11'h00A)
        else $error("wake value not 0x00A after reset");

    chk_wake_match_osc: assert property ( // [RULE1]
        (s.phase == SIT_COARSE && !startNow
         && s.coarseLeft <= {15'h0, s.wakeMatch}) |=> oscWakeReq)
        else $error("oscillator wake missing on match");

    chk_wake_high_rsv: assert property ( // [RULE4]
        s.rValid |-> s.rData[31:12] == 20'h0)
        else $error("reserved read bits not zero");

    chk_fine_tick_rate: assert property ( // [RULE5]
        (s.phase == SIT_FINE && s.fineLeft != 16'h0 && !startNow)
        |-> ##5 (s.fineLeft != $past(s.fineLeft, 5) || s.phase != SIT_FINE
                 || $past(startNow, 4)))
        else $error("fine counter not stepping every 50 ns");

    chk_coarse_hold: assert property ( // [RULE6]
        (s.phase == SIT_COARSE && !lpTick && !startNow)
        |=> s.coarseLeft == $past(s.coarseLeft))
        else $error("coarse counter moved without low-power tick");

    chk_lp_tick_base: assert property ( // [RULE8]
        lpTick |-> baseTick && s.active)
        else $error("low-power tick without base tick");

    chk_coarse_before_fine: assert property ( // [RULE11]
        coarseRanOut |-> s.coarseLeft == 26'h0 && $past(s.coarseLeft) == 26'h0)
        else $error("fine phase entered before coarse ran out");

    chk_done_after_fine: assert property ( // [RULE11]
        fineRanOut |=> intervalDone && s.phase == SIT_IDLE ##1 !intervalDone)
        else $error("done pulse not produced after fine phase");

    chk_start_nonbeacon: assert property ( // [RULE9]
        (wrStart && !nonBeacon && !beaconStart && s.phase == SIT_IDLE)
        |=> s.phase == SIT_IDLE)
        else $error("start bit accepted in beacon mode");

    chk_beacon_start: assert property ( // [RULE7]
        (beaconStart && !nonBeacon) |=> s.phase == SIT_COARSE && sleepActive)
        else $error("beacon start did not launch timers");

endmodule

`default_nettype wire

// file: verif/tb.sv
// Purpose: self-checking bench of the sleep interval timer
// Assumes: byte address = 4 * register index, 100 MHz clk
// Notes:   timing is judged in windows, the low-power tick phase is free
`timescale 1ns/1ps
`default_nettype none
`include "sit_defines.svh"

module tb import sit_pkg::*;;
// ----------------------------------------------------------------------
// stimulus and monitor
// ----------------------------------------------------------------------
logic        clk = 1'h0;
logic        nrst = 1'h0;
logic [11:0] awaddr = 12'h0;
logic [11:0] araddr = 12'h0;
logic [31:0] wdata = 32'h0;
logic        awvalid = 1'h0;
logic        wvalid = 1'h0;
logic        bready = 1'h0;
logic        arvalid = 1'h0;
logic        rready = 1'h0;
logic        bstart = 1'h0;
logic        awready, wready, bvalid, arready, rvalid;
logic        oscWakeReq, intervalDone, sleepActive;
logic [1:0]  bresp, rresp;
logic [31:0] rdata;
int          mismatches = 0;
int          n_checks = 0;
int          cyc = 0;
int          doneCyc = -1;
int          oscCyc = -1;
int          mdl [int];

always #5 clk = ~clk;

sit_sleep_interval_timer DUT (
    .clk(clk), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .beaconStart(bstart), .oscWakeReq(oscWakeReq),
    .intervalDone(intervalDone), .sleepActive(sleepActive)
);

// pre-edge values are what the design showed in the ended cycle
always @(posedge clk) begin
    cyc <= cyc + 1;
    if (intervalDone === 1'h1) doneCyc <= cyc;
    if (oscWakeReq === 1'h1 && oscCyc < 0) oscCyc <= cyc;
end

// ----------------------------------------------------------------------
// compare, model and bus tasks
// ----------------------------------------------------------------------
task automatic chk_val(string n, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
        mismatches++;
        $display("unexpected %s: expected %0h seen %0h", n, e, g);
    end
endtask

task automatic chk_win(string n, int lo, int hi, int g);
    n_checks++;
    if (g < lo || g > hi) begin
        mismatches++;
        $display("unexpected %s: expected %0d..%0d seen %0d", n, lo, hi, g);
    end
endtask

function automatic int mask(int i);
    if (i == `SIT_IDX_WAKE_HIGH) return 32'h7;
    if (i == `SIT_IDX_COARSE3) return 32'h3;
    if (i == `SIT_IDX_CTRL) return 32'hFFF;
    return 32'hFF;
endfunction

function automatic int resp(int i);
    return mdl.exists(i) ? `SIT_RESP_OKAY : `SIT_RESP_SLVERR;
endfunction

task automatic wr(int i, logic [31:0] d);
    logic a;
    logic w;
    a = 1'h1;
    w = 1'h1;
    @(posedge clk);
    awaddr  <= 12'(i * 4);
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
        @(posedge clk);
        if (a && awready) begin
            a = 1'h0;
            awvalid <= 1'h0;
        end
        if (w && wready) begin
            w = 1'h0;
            wvalid <= 1'h0;
        end
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk_val("bresp", resp(i), 32'(bresp));
    if (mdl.exists(i)) mdl[i] = d & mask(i);
endtask

task automatic rd(int i);
    logic a;
    a = 1'h1;
    @(posedge clk);
    araddr  <= 12'(i * 4);
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
        @(posedge clk);
        if (a && arready) begin
            a = 1'h0;
            arvalid <= 1'h0;
        end
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk_val("rresp", resp(i), 32'(rresp));
    chk_val("rdata", mdl.exists(i) ? mdl[i] : 0, rdata);
endtask

// configure, start, then time the wake request and the end of interval
task automatic run(int c, int f, int src, int dv, int w, bit bcn);
    logic [63:0] cfg;
    int          lp;
    int          t0;
    int          b;
    cfg = {c[31:0], f[15:0], 5'h0, w[10:0]};
    lp = ((src == 0) ? 1000 : 3051) << dv;
    wr(`SIT_IDX_CTRL, src | (dv << 2) | (bcn ? 0 : 32'h780));
    for (int k = 0; k < 8; k++) wr(`SIT_IDX_WAKE_LOW + k, cfg[8 * k +: 8]);
    t0 = cyc;
    if (bcn) begin
        @(posedge clk);
        bstart <= 1'h1;
        @(posedge clk);
        bstart <= 1'h0;
        @(posedge clk);
    end else begin
        wr(`SIT_IDX_COARSE3, 32'h80 | cfg[63:56]);
    end
    oscCyc = -1;
    @(negedge clk);
    chk_val("sleepActive", 1, sleepActive);
    while (doneCyc < t0 && cyc < t0 + 40000) @(posedge clk);
    b = c * lp + f * 5;
    chk_win("done", b - lp, b + 12, doneCyc - t0);
    // wake comes at once when the coarse count starts at or below it
    b = (c > w) ? (c - w) * lp : 0;
    chk_win("wake", (c > w) ? b - lp : 0, b + 12, oscCyc - t0);
    @(negedge clk);
    chk_val("sleepActive", 0, sleepActive);
    // status: nonbeacon, done sticky, wake held, idle; then write-one clear
    mdl[`SIT_IDX_STATUS] = bcn ? 6 : 14;
    rd(`SIT_IDX_STATUS);
    wr(`SIT_IDX_STATUS, 4);
    mdl[`SIT_IDX_STATUS] = bcn ? 2 : 10;
    rd(`SIT_IDX_STATUS);
endtask

task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
        $display("== PASSED ==");
    end else begin
        $display("== FAILED ==");
    end
    $finish;
endtask

// ----------------------------------------------------------------------
// test sequence
// ----------------------------------------------------------------------
initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    conclude();
end

initial begin
    void'($urandom(32'h2F49));
    for (int i = `SIT_IDX_WAKE_LOW; i <= `SIT_IDX_COARSE3; i++) mdl[i] = 0;
    mdl[`SIT_IDX_WAKE_LOW] = 32'(`SIT_WAKE_RESET);
    mdl[`SIT_IDX_CTRL] = 32'h780;
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    for (int i = `SIT_IDX_WAKE_LOW; i <= `SIT_IDX_CTRL; i++) rd(i);
    wr(`SIT_IDX_COARSE3 + 1, $urandom);
    // bit 7 of the top coarse byte is kept clear: it would start a run
    // wake low bit 0 stays set: a zero wake value is not allowed
    repeat (3) begin
        for (int i = `SIT_IDX_WAKE_LOW; i <= `SIT_IDX_COARSE3; i++) begin
            wr(i, ($urandom & 32'hFFFFFF7F) | 32'(i == `SIT_IDX_WAKE_LOW));
            rd(i);
        end
    end
    wr(`SIT_IDX_WAKE_HIGH, 32'hFF);
    rd(`SIT_IDX_WAKE_HIGH);
    run(0, 0, 0, 0, 10, 0);
    run(12, $urandom_range(40, 1), 0, 1, 4, 0);
    run(3, $urandom_range(40, 1), 1, 0, 1, 0);
    run(1, 16'h0203, 0, 0, 1, 0);
    wr(`SIT_IDX_CTRL, 0);
    wr(`SIT_IDX_COARSE3, 32'h80);
    @(negedge clk);
    chk_val("sleepActive", 0, sleepActive);
    rd(`SIT_IDX_COARSE3);
    run(2, 5, 0, 0, 10, 1);
    conclude();
end

endmodule
`default_nettype wire
